// [rcrg_map.vh]
// Purpose: Constants for the rate converter range guard
// Assumes: The master clock is sys_clk at 20 MHz
// Notes:   Periods are counted in master clock cycles
`ifndef RCRG_MAP_VH
`define RCRG_MAP_VH

// Clock rate in kHz, for reference by derived counts
`define RCRG_CLK_KHZ 20000
// Shortest frame period: master clock over 286
`define RCRG_MIN_PER 13'h011E
// Longest frame period: master clock over 2000
`define RCRG_MAX_PER 13'h07D0
// Period assumed for both ports after reset (ratio 1:1)
`define RCRG_INIT_PER 13'h0200
// Mute hold after reset, in master clock cycles
`define RCRG_HOLD_CYC 8'h80
// Frame edges on each port before tracking counts as settled
`define RCRG_SETTLE_EDGES 3'h4
// Guard band near 1:2 and 2:1 is period >> this shift (about 0.2 %)
`define RCRG_GUARD_SH 9
// Output full scale codes
`define RCRG_POS_FS 24'h7F_FFFF
`define RCRG_NEG_FS 24'h80_0000

`endif

// [rcrg_guard.v]
// Purpose: Output range guard of a stereo rate converter: saturation,
//          automatic mute near 1:2 and 2:1 and outside the rate window
// Assumes: Frame clocks arrive on pins; samples come from the filter core
//          on sys_clk
//          Both frame clocks run free as square waves
// Notes:   Samples pass through a two-entry buffer toward the sink
//          A partial first frame after reset is covered by the settle count
`timescale 1ns/1ps
`default_nettype none
`include "rcrg_map.vh"

// Contract
// - Overflowing interpolated sample becomes full scale
// - Mute before exact 1:2 or 2:1
// - No mute farther than one percent from limits
// - No dither added to samples
// - Mute silences both channels together
// - Rate window is master clock over 286..2000
// - Shared reset gives identical deterministic processing
// - Equal or synchronous rates run unmuted
// - Ratio tracking starts at one to one
// - Mute high 128 cycles and while settling
module rcrg_guard #(
    parameter ACC_W = 27,
    parameter OUT_W = 24,
    parameter PER_W = 13
) (
    input wire sys_clk, // Master clock
    input wire resetn, // Synchronous reset, active low
    input wire lr_in_pin, // Input frame clock pin
    input wire lr_out_pin, // Output frame clock pin
    input wire in_valid, // Accumulator samples valid
    output wire in_ready, // Buffer can take a sample
    input wire [ACC_W-1:0] acc_left, // Left accumulator value
    input wire [ACC_W-1:0] acc_right, // Right accumulator value
    output reg out_valid, // Output sample pair valid
    input wire out_ready, // Sink takes the pair
    output reg [OUT_W-1:0] out_left, // Left output word
    output reg [OUT_W-1:0] out_right, // Right output word
    output reg mute // Automatic mute, active high
);

    // Clamp an accumulator value into the output word
    function [OUT_W-1:0] rcrg_sat;
        input [ACC_W-1:0] v;
        reg [ACC_W-OUT_W:0] top;
        begin
            top = v[ACC_W-1:OUT_W-1];
            if (top == {(ACC_W-OUT_W+1){1'b0}} || top == {(ACC_W-OUT_W+1){1'b1}}) begin
                rcrg_sat = v[OUT_W-1:0];
            end else if (v[ACC_W-1]) begin
                rcrg_sat = `RCRG_NEG_FS;
            end else begin
                rcrg_sat = `RCRG_POS_FS;
            end
        end
    endfunction

    // True when a is within the guard band of twice b
    function rcrg_near_double;
        input [PER_W-1:0] a;
        input [PER_W-1:0] b;
        reg [PER_W+1:0] two_b;
        reg [PER_W+1:0] diff;
        begin
            two_b = {1'b0, b, 1'b0};
            if (two_b > {2'b00, a}) begin
                diff = two_b - {2'b00, a};
            end else begin
                diff = {2'b00, a} - two_b;
            end
            rcrg_near_double = diff <= ({2'b00, a} >> `RCRG_GUARD_SH);
        end
    endfunction

    // True when a frame period lies outside the accepted rate window
    function rcrg_off_window;
        input [PER_W-1:0] p;
        begin
            rcrg_off_window = (p < `RCRG_MIN_PER) || (p > `RCRG_MAX_PER);
        end
    endfunction

    wire [1:0] pin_w;
    wire [2*PER_W-1:0] per_w;
    wire [1:0] settled_w;
    wire [1:0] stalled_w;
    assign pin_w = {lr_out_pin, lr_in_pin};

    // Per-port synchroniser, edge detector and period meter
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : port
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg filt_q;
            reg [PER_W-1:0] cnt_q;
            reg [PER_W-1:0] per_q;
            reg [2:0] edges_q;
            wire filt_d;
            wire rise;
            // A level counts once the second and third stages agree
            assign filt_d = (s2_q == s3_q) ? s3_q : filt_q;
            assign rise = filt_d & ~filt_q;
            assign per_w[g*PER_W +: PER_W] = per_q;
            assign settled_w[g] = edges_q == `RCRG_SETTLE_EDGES;
            // A stopped frame clock would leave a legal period behind
            assign stalled_w[g] = cnt_q > `RCRG_MAX_PER;
            always @(posedge sys_clk) begin
                if (!resetn) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    filt_q <= 1'b0;
                    cnt_q <= {PER_W{1'b0}};
                    per_q <= `RCRG_INIT_PER;
                    edges_q <= 3'h0;
                end else begin
                    s1_q <= pin_w[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    filt_q <= filt_d;
                    if (rise) begin
                        per_q <= cnt_q;
                        cnt_q <= {{(PER_W-1){1'b0}}, 1'b1};
                        if (edges_q != `RCRG_SETTLE_EDGES) begin
                            edges_q <= edges_q + 3'h1;
                        end
                    end else if (cnt_q != {PER_W{1'b1}}) begin
                        cnt_q <= cnt_q + {{(PER_W-1){1'b0}}, 1'b1};
                    end
                end
            end
        end
    endgenerate

    wire [PER_W-1:0] per_in;
    wire [PER_W-1:0] per_out;
    assign per_in = per_w[PER_W-1:0];
    assign per_out = per_w[2*PER_W-1:PER_W];

    reg [7:0] hold_q;
    reg mute_d;
    reg range_bad;
    reg ratio_bad;

    always @* begin
        range_bad = rcrg_off_window(per_in) || rcrg_off_window(per_out) || (|stalled_w);
        // Band far narrower than one percent
        ratio_bad = rcrg_near_double(per_in, per_out) || rcrg_near_double(per_out, per_in);
        // Equal periods raise no ratio mute
        mute_d = (hold_q != `RCRG_HOLD_CYC) || !(&settled_w) || range_bad || ratio_bad;
    end

    // Hold count lets the pipeline drain before mute can drop
    always @(posedge sys_clk) begin
        if (!resetn) begin
            hold_q <= 8'h00;
            mute <= 1'b1;
        end else begin
            if (hold_q != `RCRG_HOLD_CYC) begin
                hold_q <= hold_q + 8'h01;
            end
            mute <= mute_d;
        end
    end

    wire [OUT_W-1:0] new_left;
    wire [OUT_W-1:0] new_right;
    assign new_left = mute ? {OUT_W{1'b0}} : rcrg_sat(acc_left);
    assign new_right = mute ? {OUT_W{1'b0}} : rcrg_sat(acc_right);

    // Two-entry buffer: output register plus skid register
    reg skid_empty_q;
    reg [OUT_W-1:0] skid_left_q;
    reg [OUT_W-1:0] skid_right_q;
    wire accept;
    assign in_ready = skid_empty_q;
    assign accept = in_valid & skid_empty_q;

    always @(posedge sys_clk) begin
        if (!resetn) begin
            out_valid <= 1'b0;
            out_left <= {OUT_W{1'b0}};
            out_right <= {OUT_W{1'b0}};
            skid_empty_q <= 1'b1;
            skid_left_q <= {OUT_W{1'b0}};
            skid_right_q <= {OUT_W{1'b0}};
        end else if (out_ready || !out_valid) begin
            // A parked pair always leaves before a new pair enters
            if (!skid_empty_q) begin
                out_valid <= 1'b1;
                out_left <= skid_left_q;
                out_right <= skid_right_q;
                skid_empty_q <= 1'b1;
            end else begin
                out_valid <= accept;
                if (accept) begin
                    out_left <= new_left;
                    out_right <= new_right;
                end
            end
        end else if (accept) begin
            skid_left_q <= new_left;
            skid_right_q <= new_right;
            skid_empty_q <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// [rcrg_guard_properties.sv]
// Purpose: Port assertions for the range guard
// Assumes: One clock, sync active-low reset
// Notes: Bound to rcrg_guard
`timescale 1ns/1ps
`default_nettype none
module rcrg_props (
    input wire logic sys_clk, // Clock
    input wire logic resetn, // Reset
    input wire logic in_valid, // Pair offered
    input wire logic in_ready, // Buffer free
    input wire logic [26:0] acc_left, // Left value
    input wire logic [26:0] acc_right, // Right value
    input wire logic out_valid, // Pair shown
    input wire logic out_ready, // Sink takes
    input wire logic [23:0] out_left, // Left word
    input wire logic [23:0] out_right, // Right word
    input wire logic mute // Muted
);
    logic [7:0] age_q;
    logic [23:0] exp_l, exp_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    function automatic logic [23:0] cut(input logic [26:0] v, input logic m);
        if (m) return 24'h00_0000;
        if (v[26:23] == 4'h0 || v[26:23] == 4'hF) return v[23:0];
        return v[26] ? 24'h80_0000 : 24'h7F_FFFF;
    endfunction
    assign exp_l = cut(acc_left, mute);
    assign exp_r = cut(acc_right, mute);
    always @(posedge sys_clk) begin
        if (!resetn) age_q <= 8'h00;
        else if (age_q != 8'hFF) age_q <= age_q + 8'h01;
    end
    sequence s_take; in_valid && in_ready && (!out_valid || out_ready); endsequence
    sequence s_park; in_valid && in_ready && out_valid && !out_ready; endsequence
    property p_left; s_take |=> out_valid && out_left == $past(exp_l); endproperty
    a_left: assert property (p_left) else $error("left word wrong");
    property p_right; s_take |=> out_right == $past(exp_r); endproperty
    a_right: assert property (p_right) else $error("right word wrong");
    property p_mute; s_take ##0 mute |=> out_left == 24'h0 && out_right == 24'h0; endproperty
    a_mute: assert property (p_mute) else $error("muted pair not silent");
    property p_hold; age_q < 8'h80 |-> mute; endproperty
    a_hold: assert property (p_hold) else $error("mute dropped early");
    property p_stall; out_valid && !out_ready |=> out_valid && $stable(out_left) && $stable(out_right); endproperty
    a_stall: assert property (p_stall) else $error("held pair changed");
    property p_park; s_park |=> !in_ready; endproperty
    a_park: assert property (p_park) else $error("buffer not full");
    property p_drain; out_valid && out_ready && !in_ready |=> out_valid && in_ready; endproperty
    a_drain: assert property (p_drain) else $error("waiting pair lost");
    property p_idle; !out_valid && in_ready && !in_valid |=> !out_valid; endproperty
    a_idle: assert property (p_idle) else $error("spurious pair");
endmodule
bind rcrg_guard rcrg_props u_props (.sys_clk, .resetn, .in_valid, .in_ready, .acc_left, .acc_right,
    .out_valid, .out_ready, .out_left, .out_right, .mute);
`default_nettype wire

// [rcrg_far_end.sv]
// Purpose: Frame clock source and stalling sink
// Assumes: Periods in master clock cycles
// Notes: Pin edges never meet a clock edge
`timescale 1ns/1ps
`default_nettype none
module rcrg_far_end (
    input wire logic sys_clk, // Clock
    input wire logic [11:0] per_in, // Input frame period
    input wire logic [11:0] per_out, // Output frame period
    input wire logic stall_en, // Random stalls
    output logic lr_in_pin, // Input frame pin
    output logic lr_out_pin, // Output frame pin
    output logic out_ready // Sink ready
);
    real half_bit;
    logic bclk_out;
    initial begin
        lr_in_pin = 1'b0;
        #13;
        forever #(per_in * 25) lr_in_pin = ~lr_in_pin;
    end
    // Output port runs a 64x bit clock; the frame pin follows it
    initial begin
        lr_out_pin = 1'b0;
        bclk_out = 1'b0;
        #13;
        forever begin
            half_bit = per_out * 25.0 / 64.0;
            repeat (64) #(half_bit) bclk_out = ~bclk_out;
            lr_out_pin = ~lr_out_pin;
        end
    end
    initial begin
        out_ready = 1'b1;
        forever @(posedge sys_clk) #1 out_ready = !stall_en || ($urandom % 2 == 0);
    end
endmodule
`default_nettype wire

// [testbench.sv]
// Purpose: Self-checking bench for the range guard
// Assumes: 20 MHz clock
// Notes: Expected pairs queued at acceptance
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk, resetn, in_valid, stall_en;
    logic [26:0] acc_left, acc_right;
    logic [11:0] per_in, per_out;
    wire lr_in_pin, lr_out_pin, in_ready, out_valid, out_ready, mute;
    wire [23:0] out_left, out_right;
    int mismatches, comparisons, cyc;
    logic [47:0] exp_q[$];
    int tpi[6] = '{600, 600, 600, 600, 300, 600};
    int tpo[6] = '{600, 299, 300, 250, 600, 2400};
    bit tm[6] = '{0, 0, 1, 1, 1, 1};
    rcrg_guard DUT (.sys_clk, .resetn, .lr_in_pin, .lr_out_pin, .in_valid, .in_ready, .acc_left,
        .acc_right, .out_valid, .out_ready, .out_left, .out_right, .mute);
    rcrg_far_end u_far (.sys_clk, .per_in, .per_out, .stall_en, .lr_in_pin, .lr_out_pin, .out_ready);
    function automatic logic [23:0] fs(logic [26:0] v, logic m);
        if (m) return 24'h00_0000;
        if (v[26:23] == 4'h0 || v[26:23] == 4'hF) return v[23:0];
        return v[26] ? 24'h80_0000 : 24'h7F_FFFF;
    endfunction
    task automatic chk_pair(logic [47:0] got, logic [47:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %0t pair got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(logic [2:0] got, logic [2:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %0t flags got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk_count(int got, int exp);
        comparisons++;
        if (got != exp) begin
            mismatches++;
            $display("mismatch %0t count got %0d exp %0d", $time, got, exp);
        end
    endtask
    task automatic send(int n);
        logic [31:0] a;
        repeat (n) begin
            a = $urandom;
            in_valid = 1'b1;
            acc_left = a[3] ? a[26:0] : {{4{a[22]}}, a[22:0]};
            acc_right = 27'($urandom);
            do @(negedge sys_clk); while (in_ready !== 1'b1);
            exp_q.push_back({fs(acc_left, mute), fs(acc_right, mute)});
            @(posedge sys_clk) #1;
        end
        in_valid = 1'b0;
    endtask
    task conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            conclude();
        end
    end
    always @(negedge sys_clk) begin
        if (resetn && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (exp_q.size() == 0) chk_count(1, 0);
            else chk_pair({out_left, out_right}, exp_q.pop_front());
        end
    end
    initial begin
        void'($urandom(66));
        {resetn, in_valid, acc_left, acc_right} = '0;
        per_in = 12'd600;
        per_out = 12'd600;
        stall_en = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk_flag({out_valid, in_ready, mute}, 3'b011);
        resetn = 1'b1;
        send(10);
        repeat (200) @(posedge sys_clk);
        #1 chk_flag(mute, 1'b1);
        for (int i = 0; i < 4000 && mute; i++) @(posedge sys_clk) #1;
        foreach (tm[i]) begin
            per_in = 12'(tpi[i]);
            per_out = 12'(tpo[i]);
            repeat (5000) @(posedge sys_clk);
            #1 chk_flag(mute, tm[i]);
            if (i % 2 == 0) send(40);
        end
        repeat (40) @(posedge sys_clk);
        chk_count(exp_q.size(), 0);
        conclude();
    end
endmodule
`default_nettype wire
